//--- cmb_params.svh
// constants of the can message buffer manager: sizes, byte slots, reset values
// assumes inclusion by bare name from the design file
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH

`define CMB_TX_BUFS       3
`define CMB_TX_BYTES      16
`define CMB_TX_LOCAL_PRIORITY_FIELD_SLOT  4'hd
`define CMB_TX_TS_HI_SLOT 4'he
`define CMB_TX_TS_LO_SLOT 4'hf
`define CMB_RX_STAGES     5
`define CMB_RX_BYTES      15
`define CMB_SEL_RESET     3'h0
`define CMB_EMPTY_RESET   3'h7

`endif

//--- cmb_pkg.sv
// types shared by the can message buffer manager and its bench
// assumes cmb_params.svh sits in the same folder
`default_nettype none

package cmb_pkg;
    // one byte write into a buffer window
    typedef struct packed {
        logic       wr;
        logic [3:0] addr;
        logic [7:0] data;
    } cmb_byte_wr_t;
endpackage

`default_nettype wire

//--- cmb_buffer_manager.sv
// can message storage: three transmit buffers with local priority and abort,
// and a five stage receive fifo with foreground/background buffers
// assumes the protocol engine and the cpu logic run on core_clk
//
// Notes on behaviour
// - exactly three independent transmit buffers for back to back queueing
// - each transmit buffer: 13 message bytes, 8-bit priority, 2 stamp bytes
// - successful send sets the empty flag and raises a transmit event
// - among pending buffers the lowest priority value is sent first
// - only non-empty buffers compete before start of frame; ties go low index
// - selection reruns on every arbitration, retries after errors included
// - software may request abort; a frame already started is never aborted
// - granted abort sets acknowledge and empty, raises transmit event
// - five stage receive fifo; only the foreground stage is cpu visible
// - each receive buffer holds 15 bytes of control, id, data, stamp
// - receive full flag set when foreground holds an accepted message
// - frame fills background; valid completion shifts it in, raises event
// - next background buffer is ready as soon as interframe space ends
// - invalid frames are not shifted; next frame overwrites the buffer
// - own frames captured but not stored, signalled or acknowledged
// - in loopback own frames are handled like any received frame
// - after lost arbitration the winning frame is received normally
// - accepted frame into a full fifo is discarded with overrun event
// - transmit goes on while full; accepting resumes once a stage frees
`default_nettype none
`include "cmb_params.svh"

module cmb_buffer_manager #(
    parameter int TX_BUFS   = `CMB_TX_BUFS,
    parameter int RX_STAGES = `CMB_RX_STAGES
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // cpu: buffer select and transmit window
    input  wire logic                  sel_wr,
    input  wire logic [TX_BUFS-1:0]    sel_data,
    input  wire cmb_pkg::cmb_byte_wr_t tx_win_wr,
    input  wire logic [3:0]            tx_win_rd_addr,
    input  wire logic [TX_BUFS-1:0]    tx_empty_clr,
    input  wire logic [TX_BUFS-1:0]    abort_req_set,
    output var  logic [TX_BUFS-1:0]    tx_buffer_select_reg,
    output var  logic [7:0]            tx_win_rdata,
    output var  logic [TX_BUFS-1:0]    tx_flag_reg,
    output var  logic [TX_BUFS-1:0]    abort_request_reg,
    output var  logic [TX_BUFS-1:0]    abort_ack_reg,
    output var  logic                  tx_event,
    // cpu: receive foreground
    input  wire logic [3:0]            rx_fg_rd_addr,
    input  wire logic                  rx_full_clr,
    input  wire logic                  loopback,
    output var  logic [7:0]            rx_fg_data,
    output var  logic                  rx_full_flag,
    output var  logic                  rx_event,
    output var  logic                  overrun_event,
    // engine: transmit side
    input  wire logic                  eng_arb,
    input  wire logic                  eng_tx_start,
    input  wire logic                  eng_tx_done,
    input  wire logic                  eng_tx_fail,
    input  wire logic [15:0]           eng_ts,
    input  wire logic [3:0]            eng_tx_addr,
    output var  logic                  pick_valid,
    output var  logic [1:0]            pick_idx,
    output var  logic [7:0]            eng_tx_data,
    // engine: receive side
    input  wire cmb_pkg::cmb_byte_wr_t eng_rx_wr,
    input  wire logic                  eng_rx_ok,
    input  wire logic                  eng_rx_own,
    output var  logic                  rx_ack_enable
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // lowest set bit as a one-hot vector
    function automatic logic [TX_BUFS-1:0] lowest_one(input logic [TX_BUFS-1:0] v);
        logic [TX_BUFS-1:0] r;
        r = '0;
        for (int i = TX_BUFS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // index of a one-hot vector
    function automatic logic [1:0] oh_index(input logic [TX_BUFS-1:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < TX_BUFS; i++) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // ring pointer step over the receive stages
    function automatic logic [2:0] ptr_step(input logic [2:0] p);
        return (p == 3'(RX_STAGES - 1)) ? 3'h0 : p + 3'h1;
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0]         tx_mem [TX_BUFS][`CMB_TX_BYTES];
    logic [7:0]         rx_mem [RX_STAGES][`CMB_RX_BYTES];
    logic               tx_busy;
    logic [2:0]         wr_ptr;
    logic [2:0]         rd_ptr;
    logic [2:0]         rx_count;

    // ------------------------------------------------------------
    // transmit selection and abort decode
    // ------------------------------------------------------------
    logic [TX_BUFS-1:0] next_sel;
    logic [1:0]         sel_idx;
    logic [TX_BUFS-1:0] pending;
    logic [1:0]         best_idx;
    logic               best_found;
    logic [TX_BUFS-1:0] abort_grant;
    logic [TX_BUFS-1:0] done_vec;
    logic [TX_BUFS-1:0] next_empty;
    logic               win_write_ok;

    assign next_sel     = lowest_one(sel_data & tx_flag_reg);
    assign sel_idx      = oh_index(tx_buffer_select_reg);
    assign win_write_ok = tx_win_wr.wr && (|(tx_buffer_select_reg & tx_flag_reg))
                          && (tx_win_wr.addr <= `CMB_TX_LOCAL_PRIORITY_FIELD_SLOT);
    assign pending      = ~tx_flag_reg;

    always_comb begin
        best_found = 1'b0;
        best_idx   = 2'h0;
        for (int i = 0; i < TX_BUFS; i++) begin
            // strict compare keeps lower index on a tie
            if (pending[i] && (!best_found ||
                tx_mem[i][`CMB_TX_LOCAL_PRIORITY_FIELD_SLOT] < tx_mem[best_idx][`CMB_TX_LOCAL_PRIORITY_FIELD_SLOT])) begin
                best_found = 1'b1;
                best_idx   = 2'(i);
            end
        end
    end

    // a started frame is never aborted; a start in the same cycle beats the grant
    // otherwise the engine would send a buffer that software already sees released
    always_comb begin
        for (int i = 0; i < TX_BUFS; i++) begin
            abort_grant[i] = abort_request_reg[i] && pending[i]
                             && !((tx_busy || (eng_tx_start && pick_valid))
                                  && pick_idx == 2'(i));
            done_vec[i]    = eng_tx_done && tx_busy && pick_idx == 2'(i);
        end
    end

    // set wins over a software clear in the same cycle
    assign next_empty = (tx_flag_reg & ~tx_empty_clr) | done_vec | abort_grant;

    // ------------------------------------------------------------
    // transmit buffer memory
    // ------------------------------------------------------------

    // three buffers, sixteen byte slots each
    always_ff @(posedge core_clk) begin
        if (win_write_ok) begin
            tx_mem[sel_idx][tx_win_wr.addr] <= tx_win_wr.data;
        end
        if (eng_tx_done && tx_busy) begin
            tx_mem[pick_idx][`CMB_TX_TS_HI_SLOT] <= eng_ts[15:8];
            tx_mem[pick_idx][`CMB_TX_TS_LO_SLOT] <= eng_ts[7:0];
        end
    end

    // cpu window read; stale content is hidden while the buffer is queued
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_win_rdata <= 8'h00;
        end else begin
            tx_win_rdata <= (|(tx_buffer_select_reg & tx_flag_reg))
                            ? tx_mem[sel_idx][tx_win_rd_addr] : 8'h00;
        end
    end

    // engine fetches bytes of the picked buffer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            eng_tx_data <= 8'h00;
        end else begin
            eng_tx_data <= tx_mem[pick_idx][eng_tx_addr];
        end
    end

    // ------------------------------------------------------------
    // transmit flags
    // ------------------------------------------------------------

    // select pointer into the shared window
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_buffer_select_reg <= `CMB_SEL_RESET;
        end else if (sel_wr) begin
            tx_buffer_select_reg <= next_sel;
        end
    end

    // sent sets empty, abort sets ack and empty
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_flag_reg       <= `CMB_EMPTY_RESET;
            abort_ack_reg     <= '0;
            abort_request_reg <= '0;
            tx_event          <= 1'b0;
        end else begin
            tx_flag_reg       <= next_empty;
            // one means aborted, zero means sent
            abort_ack_reg     <= (abort_ack_reg & ~tx_empty_clr & ~done_vec) | abort_grant;
            abort_request_reg <= (abort_request_reg | (abort_req_set & pending)) & ~next_empty;
            tx_event          <= |(done_vec | abort_grant);
        end
    end

    // pick taken at every arbitration, retries too
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pick_valid <= 1'b0;
            pick_idx   <= 2'h0;
            tx_busy    <= 1'b0;
        end else begin
            if (eng_arb && !tx_busy) begin
                pick_valid <= best_found;
                pick_idx   <= best_idx;
            end else if (abort_grant[pick_idx] || eng_tx_done || eng_tx_fail) begin
                pick_valid <= 1'b0;
            end
            // start locks the buffer against abort
            if (eng_tx_start && pick_valid) begin
                tx_busy <= 1'b1;
            end else if (eng_tx_done || eng_tx_fail) begin
                tx_busy <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // receive fifo
    // ------------------------------------------------------------
    logic       rx_full;
    logic       own_blocked;
    logic       push;
    logic       pop;
    logic [2:0] next_count;

    assign rx_full     = (rx_count == 3'(RX_STAGES));
    // own frame outside loopback, loopback treats it normally
    assign own_blocked = eng_rx_own && !loopback;
    // valid completion shifts, invalid frames never do
    assign push        = eng_rx_ok && !own_blocked && !rx_full;
    assign pop         = rx_full_clr && (rx_count != 3'h0);
    assign next_count  = rx_count + 3'(push) - 3'(pop);

    // background is the stage at the write pointer
    // writes dropped while every stage is occupied
    always_ff @(posedge core_clk) begin
        if (eng_rx_wr.wr && !rx_full && eng_rx_wr.addr < 4'(`CMB_RX_BYTES)) begin
            rx_mem[wr_ptr][eng_rx_wr.addr] <= eng_rx_wr.data;
        end
    end

    // pointer advances at completion, so next frame finds a fresh stage
    // without a push the same stage is overwritten
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr   <= 3'h0;
            rd_ptr   <= 3'h0;
            rx_count <= 3'h0;
        end else begin
            wr_ptr   <= push ? ptr_step(wr_ptr) : wr_ptr;
            rd_ptr   <= pop ? ptr_step(rd_ptr) : rd_ptr;
            rx_count <= next_count;
        end
    end

    // full flag tracks foreground occupancy; a push beats the clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_full_flag  <= 1'b0;
            rx_event      <= 1'b0;
            overrun_event <= 1'b0;
            rx_fg_data    <= 8'h00;
        end else begin
            rx_full_flag  <= (next_count != 3'h0);
            rx_event      <= push;
            // accepted frame lost to a full fifo
            overrun_event <= eng_rx_ok && !own_blocked && rx_full;
            rx_fg_data    <= (rx_count != 3'h0) ? rx_mem[rd_ptr][rx_fg_rd_addr] : 8'h00;
        end
    end

    // no acknowledge of own frames while sending, except in loopback
    // after lost arbitration tx_busy drops and acknowledging resumes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_ack_enable <= 1'b1;
        end else begin
            rx_ack_enable <= !(tx_busy && !loopback);
        end
    end

endmodule

`default_nettype wire

//--- cmb_buffer_manager_sva.sv
// port assertions for the can message buffer manager
// assumes a single core_clk domain and a synchronous active high rst
`default_nettype none
module cmb_bm_sva #(
    parameter int TX_BUFS = 3
) (
    // clock and reset
    input wire logic               core_clk,
    input wire logic               rst,
    // cpu side
    input wire logic               sel_wr,
    input wire logic [TX_BUFS-1:0] sel_data,
    input wire logic [TX_BUFS-1:0] tx_buffer_select_reg,
    input wire logic [TX_BUFS-1:0] tx_flag_reg,
    input wire logic [TX_BUFS-1:0] abort_ack_reg,
    input wire logic               tx_event,
    input wire logic               loopback,
    input wire logic               rx_full_flag,
    input wire logic               rx_event,
    input wire logic               overrun_event,
    // engine side
    input wire logic               eng_arb,
    input wire logic               eng_tx_done,
    input wire logic               eng_rx_ok,
    input wire logic               eng_rx_own,
    input wire logic               pick_valid,
    input wire logic [1:0]         pick_idx
);
    logic [TX_BUFS-1:0] sel_m;
    logic [TX_BUFS-1:0] sel_low;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    assign sel_m   = sel_data & tx_flag_reg;
    assign sel_low = sel_m & (-sel_m);  // keeps only the lowest set bit
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_sent;
        pick_valid && eng_tx_done;
    endsequence
    sequence s_stored;
        eng_rx_ok && (!eng_rx_own || loopback) && !rx_full_flag;
    endsequence
    // reset leaves every buffer empty and nothing picked
    a_reset_all_empty: assert property ($fell(rst) |->
        tx_flag_reg == '1 && !pick_valid && !rx_full_flag)
        else $error("state after reset is wrong");
    // a sent buffer comes back empty, marked as sent, with one event
    a_sent_frees_buffer: assert property (s_sent |=>
        tx_flag_reg[$past(pick_idx)] && tx_event && !pick_valid
        && !abort_ack_reg[$past(pick_idx)])
        else $error("sent buffer not released as sent");
    a_pick_is_queued: assert property ($rose(pick_valid) |-> !tx_flag_reg[pick_idx])
        else $error("picked buffer is not queued");
    a_arb_gives_pick: assert property (eng_arb && !pick_valid
        && tx_flag_reg != '1 |=> pick_valid)
        else $error("arbitration made no pick");
    a_idle_no_pick: assert property (eng_arb && !pick_valid
        && tx_flag_reg == '1 |=> !pick_valid)
        else $error("pick made with no queued buffer");
    a_select_lowest: assert property (sel_wr |=> tx_buffer_select_reg == $past(sel_low))
        else $error("select pointer not lowest empty");
    a_abort_grant: assert property ((abort_ack_reg & ~$past(abort_ack_reg)) != '0 |->
        tx_event && (abort_ack_reg & ~tx_flag_reg) == '0)
        else $error("abort granted without release");
    a_rx_store: assert property (s_stored |=> rx_full_flag && rx_event)
        else $error("valid frame not stored");
    a_own_dropped: assert property (eng_rx_ok && eng_rx_own && !loopback
        |=> !rx_event && !overrun_event)
        else $error("own frame was stored");
endmodule
bind cmb_buffer_manager cmb_bm_sva #(.TX_BUFS(TX_BUFS)) u_sva (.*);
`default_nettype wire

//--- cmb_engine_model.sv
// stand-in for the can protocol engine: strobes and received frames
// assumes the bench calls its tasks; everything changes at falling edges
`default_nettype none
module cmb_engine_model (
    input  wire logic                 core_clk,
    output var  logic                 eng_arb,
    output var  logic                 eng_tx_start,
    output var  logic                 eng_tx_done,
    output var  logic                 eng_tx_fail,
    output var  logic [15:0]          eng_ts,
    output var  logic [3:0]           eng_tx_addr,
    output var  cmb_pkg::cmb_byte_wr_t eng_rx_wr,
    output var  logic                 eng_rx_ok,
    output var  logic                 eng_rx_own
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle engine; fetch index stays on the first byte
    initial begin
        {eng_arb, eng_tx_start, eng_tx_done, eng_tx_fail} = 4'h0;
        {eng_rx_ok, eng_rx_own} = 2'h0;
        eng_ts = 16'h0;
        eng_tx_addr = 4'h0;
        eng_rx_wr = '0;
    end
    // one strobe: 8 arb, 4 start, 2 done, 1 fail
    task automatic strobe(input logic [3:0] k, input logic [15:0] ts);
        @(negedge core_clk);
        {eng_arb, eng_tx_start, eng_tx_done, eng_tx_fail} = k;
        eng_ts = ts;
        @(negedge core_clk);
        {eng_arb, eng_tx_start, eng_tx_done, eng_tx_fail} = 4'h0;
        eng_ts = ~ts;  // stamp only valid with done
    endtask
    // fifteen bytes then the end-of-frame verdict
    task automatic rx_frame(input logic [7:0] base, input logic own, input logic ok);
        for (int i = 0; i < 15; i++) begin
            @(negedge core_clk);
            eng_rx_wr = '{1'b1, i[3:0], base + 8'(i)};
        end
        @(negedge core_clk);
        eng_rx_wr = '{1'b0, 4'h0, ~eng_rx_wr.data};
        eng_rx_ok = ok;
        eng_rx_own = own;
        @(negedge core_clk);
        eng_rx_ok = 1'b0;
        eng_rx_own = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- cmb_buffer_manager_bench.sv
// self-checking bench for the can message buffer manager
// assumes cmb_pkg and the engine model are compiled first
`default_nettype none
module cmb_buffer_manager_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst, sel_wr, rx_full_clr, loopback, tx_event, pick_valid;
    logic rx_full_flag, rx_event, overrun_event, rx_ack_enable;
    logic eng_arb, eng_tx_start, eng_tx_done, eng_tx_fail, eng_rx_ok, eng_rx_own;
    logic [2:0] sel_data, tx_empty_clr, abort_req_set, tx_buffer_select_reg;
    logic [2:0] tx_flag_reg, abort_request_reg, abort_ack_reg;
    logic [3:0] tx_win_rd_addr, rx_fg_rd_addr, eng_tx_addr;
    logic [7:0] tx_win_rdata, rx_fg_data, eng_tx_data;
    logic [15:0] eng_ts;
    logic [1:0] pick_idx;
    cmb_pkg::cmb_byte_wr_t tx_win_wr, eng_rx_wr;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] exp_fg [5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'ha0};
    cmb_buffer_manager dut (.*);
    cmb_engine_model eng (.*);
    always #2.5 core_clk = ~core_clk;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // select an empty buffer, then fill slots 0..13, priority in slot 13
    task automatic load(input logic [2:0] sel, input logic [7:0] local_priority_field);
        @(negedge core_clk);
        sel_wr = 1'b1;
        sel_data = sel;
        @(negedge core_clk);
        sel_wr = 1'b0;
        for (int a = 0; a < 14; a++) begin
            tx_win_wr = '{1'b1, a[3:0], (a == 13) ? local_priority_field : {sel, a[4:0]}};
            @(negedge core_clk);
        end
        tx_win_wr.wr = 1'b0;
    endtask
    // one-cycle pulses: queue buffers, request aborts, release foreground
    task automatic pulse_clr(input logic [2:0] e, input logic [2:0] ab, input logic rx);
        {tx_empty_clr, abort_req_set, rx_full_clr} = {e, ab, rx};
        cyc(1);
        {tx_empty_clr, abort_req_set, rx_full_clr} = 7'h0;
    endtask
    initial begin
        {rst, sel_wr, rx_full_clr, loopback} = 4'h8;
        {sel_data, tx_empty_clr, abort_req_set} = 9'h0;
        {tx_win_rd_addr, rx_fg_rd_addr} = 8'h0;
        tx_win_wr = '0;
        cyc(12);
        rst = 1'b0;
        check(tx_flag_reg, 3'h7);
        load(3'h6, 8'h10);
        check(tx_buffer_select_reg, 3'h2);
        tx_win_rd_addr = 4'hd;
        cyc(1);
        check(tx_win_rdata, 8'h10);
        pulse_clr(3'h2, 3'h0, 1'b0);
        load(3'h1, 8'h20);
        pulse_clr(3'h1, 3'h0, 1'b0);
        load(3'h4, 8'h10);
        pulse_clr(3'h4, 3'h0, 1'b0);
        check(tx_flag_reg, 3'h0);
        eng.strobe(4'h8, 16'h0);
        check(pick_idx, 2'h1);
        cyc(1);  // fetch byte follows the pick one cycle later
        check(eng_tx_data, 8'hc0);
        eng.strobe(4'h4, 16'h0);
        cyc(1);  // acknowledge enable follows the busy state one cycle later
        check(rx_ack_enable, 1'b0);
        eng.strobe(4'h1, 16'h0);
        cyc(1);
        check(rx_ack_enable, 1'b1);
        eng.strobe(4'h8, 16'h0);
        check({pick_valid, pick_idx}, 3'h5);
        eng.strobe(4'h4, 16'h0);
        eng.strobe(4'h2, 16'hbeef);
        check({tx_flag_reg, abort_ack_reg, tx_event}, 7'h21);
        pulse_clr(3'h0, 3'h1, 1'b0);
        check(abort_request_reg, 3'h1);
        cyc(1);
        check({tx_flag_reg, abort_ack_reg, tx_event}, 7'h33);
        load(3'h2, 8'h00);
        tx_win_rd_addr = 4'he;
        cyc(1);
        check(tx_win_rdata, 8'hbe);
        tx_win_rd_addr = 4'hf;
        cyc(1);
        check(tx_win_rdata, 8'hef);
        eng.strobe(4'h8, 16'h0);
        eng.strobe(4'h4, 16'h0);
        pulse_clr(3'h0, 3'h4, 1'b0);
        cyc(3);
        check({pick_valid, tx_flag_reg[2]}, 2'h2);
        eng.strobe(4'h2, 16'h1234);
        check({tx_flag_reg, abort_ack_reg}, 6'h39);
        eng.strobe(4'h8, 16'h0);
        check(pick_valid, 1'b0);
        eng.rx_frame(8'h10, 1'b0, 1'b0);
        eng.rx_frame(8'h20, 1'b0, 1'b1);
        check({rx_full_flag, rx_event}, 2'h3);
        cyc(1);
        check(rx_fg_data, 8'h20);
        rx_fg_rd_addr = 4'he;
        cyc(1);
        check(rx_fg_data, 8'h2e);
        rx_fg_rd_addr = 4'h0;
        eng.rx_frame(8'h30, 1'b1, 1'b1);
        check(rx_event, 1'b0);
        loopback = 1'b1;
        eng.rx_frame(8'h40, 1'b1, 1'b1);
        check(rx_event, 1'b1);
        loopback = 1'b0;
        for (int k = 0; k < 4; k++) begin
            eng.rx_frame(8'h50 + 8'(k * 16), 1'b0, 1'b1);
            check({rx_event, overrun_event}, {k < 3, k == 3});
        end
        pulse_clr(3'h0, 3'h0, 1'b1);
        eng.rx_frame(8'ha0, 1'b0, 1'b1);
        check(rx_event, 1'b1);
        for (int i = 0; i < 5; i++) begin
            cyc(1);
            check({rx_full_flag, rx_fg_data}, {1'b1, exp_fg[i]});
            pulse_clr(3'h0, 3'h0, 1'b1);
        end
        check(rx_full_flag, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
